// ===== elev_consts.svh
`ifndef ELEV_CONSTS_SVH
`define ELEV_CONSTS_SVH
// register offsets (byte addresses, one word each)
`define OFF_CTRL      6'h00
`define OFF_STATUS    6'h04
`define OFF_XFER_IN   6'h08
`define OFF_XFER_OUT  6'h0c
`define OFF_XFER_RNG  6'h10
`define OFF_INTERLOCK 6'h14
`define OFF_LANDING   6'h18
// ctrl field positions
`define CTRL_ONGOING  0
`define CTRL_GROUP    1
`define CTRL_GONG_DO  2
`define CTRL_LIMSW1   3
`define CTRL_LIMSW2   4
`define CTRL_TWOSIDE  5
`define CTRL_VISITOR  6
`define CTRL_RESET    32'h00000000
// sizes
`define NUM_LAND      8
`define XFER_W        16
`define ATT_W         5
// timing
`define GONG_PULSE_NS 200000000
`define GONG_GAP_NS   300000000
`define CLK_NS        10
`define GONG_PULSE_CYC (`GONG_PULSE_NS / `CLK_NS)
`define GONG_GAP_CYC  (`GONG_GAP_NS / `CLK_NS)
`define INTERLOCK_DEF 32'h000f4240
`define ROPE_HOURS    24
`define ROPE_CYC_DEF  (64'd24 * 64'd3600 * 64'd100000000)
`define INV_UNMAPPED  32'hdeadbeef
`endif

// ===== elev_pkg.sv
package elev_pkg;
    typedef enum logic [3:0] {
        VIS_IDLE = 4'b0001,
        VIS_MAIN = 4'b0010,
        VIS_DEST = 4'b0100,
        VIS_DONE = 4'b1000
    } vis_state_t;
    typedef enum logic [2:0] {
        DOOR_IDLE   = 3'b001,
        DOOR_UNLOCK = 3'b010,
        DOOR_OPEN   = 3'b100
    } door_state_t;
endpackage

// ===== elevator_status_output.sv
// Behaviour
// - special service lamp only while a privileged key or car reservation active
// - special service lamp suppressed by any higher priority status
// - firemen lamp while firemen, fire emergency or emergency travel active
// - out-of-operation contact closed when healthy, open on fault or shutdown
// - up lamp when moving up, next output is down lamp
// - with ongoing option, lamps show continuing direction at standstill
// - car gong pulses when door opens after arrival at destination
// - group with gong option: gong on every door 1 opening
// - group with gong option: gong on own-landing call while door open
// - buzzer on landing firemen start when away from fire landing, door open
// - buzzer while overloaded at a landing and while nudging active
// - voice position outputs one per landing, bottom to top
// - doors-open from limit switches if fitted, else safety contact open
// - door 1 open from its limit switch if fitted, else safety contact
// - release interlock and start timer, open door 1 only after expiry
// - two access sides: same sequence for door 2 interlock
// - inputs first..last copied to outputs, count is difference plus one
// - smoke at evacuation landing: backup, else above, else below
// - sound button: two gong strokes going up, one going down
// - visitor input acknowledged; standstill sequence to main then visitor landing
// - rope brake test requested every 24 hours
// - five contiguous inputs reserved for attendant control
//
// The Avalon-MM interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/10ps
`include "elev_consts.svh"
module elevator_status_output #(
    parameter logic [63:0] ROPE_CYC = `ROPE_CYC_DEF   // rope brake test interval
) (
    input  wire logic                  clk,             // 100 MHz clock
    input  wire logic                  rst_n,           // async reset, active low
    input  wire logic [5:0]            avs_address,     // byte address
    input  wire logic                  avs_read,        // read strobe
    input  wire logic                  avs_write,       // write strobe
    input  wire logic [31:0]           avs_writedata,   // write data
    input  wire logic [3:0]            avs_byteenable,  // byte lanes
    output logic [31:0]                avs_readdata,    // read data
    output logic                       avs_waitrequest, // stall
    input  wire logic                  key_special,     // special service key
    input  wire logic                  key_priority,    // priority travel key
    input  wire logic                  key_shutdown,    // shut-down key
    input  wire logic                  key_firemen,     // firemen key
    input  wire logic                  key_fire_emerg,  // fire emergency key
    input  wire logic                  car_reserved,    // car reservation
    input  wire logic                  higher_prio,     // e.g. excess temperature
    input  wire logic                  st_firemen,      // firemen mode active
    input  wire logic                  st_fire_emerg,   // fire emergency active
    input  wire logic                  st_emerg_travel, // emergency travel active
    input  wire logic                  st_fault,        // malfunction
    input  wire logic                  st_shutdown,     // shut down
    input  wire logic                  moving_up,       // car moving up
    input  wire logic                  moving_down,     // car moving down
    input  wire logic                  cont_up,         // continuing direction up
    input  wire logic                  cont_down,       // continuing direction down
    input  wire logic                  at_dest,         // arrived at destination
    input  wire logic                  door_opening,    // door open command seen
    input  wire logic                  own_land_call,   // landing call at car's landing
    input  wire logic                  firemen_start,   // landing firemen initiated
    input  wire logic                  at_fire_land,    // car at fireman landing
    input  wire logic                  at_landing,      // car level at a landing
    input  wire logic                  overload,        // overload condition
    input  wire logic                  nudging,         // nudging signal active
    input  wire logic [2:0]            car_pos,         // landing index
    input  wire logic                  pass_landing,    // pulse when passing a landing
    input  wire logic                  sound_button,    // blind passenger button
    input  wire logic                  door_safety_contact, // closed = 1
    input  wire logic                  limsw1_open,     // door 1 open limit
    input  wire logic                  limsw2_open,     // door 2 open limit
    input  wire logic                  open_req1,       // open request door 1
    input  wire logic                  open_req2,       // open request door 2
    input  wire logic                  smoke,           // fire detector
    input  wire logic                  backup_ok,       // backup landing reachable
    input  wire logic                  above_ok,        // landing above reachable
    input  wire logic                  visitor_in,      // visitor input
    input  wire logic                  car_cmds,        // car commands pending
    input  wire logic                  travel_done,     // travel finished pulse
    input  wire logic                  rope_brake_ok,   // rope brake test input
    input  wire logic [`ATT_W-1:0]     attendant_in,    // attendant control group
    input  wire logic [`XFER_W-1:0]    xfer_in,         // transfer inputs
    output logic                       special_lamp,    // special service
    output logic                       firemen_lamp,    // firemen / fire emergency
    output logic                       out_of_op_ok,    // break contact, 1 = closed
    output logic [1:0]                 dir_lamp,        // [0] up, [1] down
    output logic                       car_gong,        // in-car gong
    output logic                       buzzer,          // acoustic signal
    output logic [`NUM_LAND-1:0]       voice_pos,       // position announcement
    output logic                       doors_open,      // any door open
    output logic                       door1_open,      // door 1 open
    output logic                       interlock1,      // door 1 interlock release
    output logic                       interlock2,      // door 2 interlock release
    output logic                       door1_cmd,       // open door 1
    output logic                       door2_cmd,       // open door 2
    output logic [`XFER_W-1:0]         xfer_out,        // transferred signals
    output logic [1:0]                 evac_target,     // 0 main,1 backup,2 above,3 below
    output logic                       visitor_ack,     // visitor acknowledged
    output logic [1:0]                 visitor_goal,    // 1 main, 2 visitors' landing
    output logic                       rope_test_req,   // rope brake test strobe
    output logic [`ATT_W-1:0]          attendant_q      // attendant inputs held
);
    typedef struct packed {
        logic [31:0]               ctrl;
        logic [31:0]               ilk_time;
        logic [3:0]                xfer_first;
        logic [3:0]                xfer_last;
        logic [31:0]               rdata;
        logic                      ack;
        logic                      special, firemen, oop, buzz, dopen, d1open;
        logic [1:0]                dir;
        logic [`NUM_LAND-1:0]      voice;
        logic [`XFER_W-1:0]        xout;
        logic [1:0]                evac;
        logic                      gong;
        logic [31:0]               gong_cnt;
        logic [1:0]                strokes;
        logic                      door_prev;
        elev_pkg::door_state_t     d1, d2;
        logic [31:0]               t1, t2;
        elev_pkg::vis_state_t      vis;
        logic                      vack;
        logic [63:0]               rope_cnt;
        logic                      rope_req;
        logic                      rope_fail;
        logic [`ATT_W-1:0]         att;
    } state_t;

    state_t q, n;
    logic   dev_open1, dev_open2, vis_start;

    always_comb begin
        n = q;
        // one wait state: ack rises after the first request cycle, drops after the second
        n.ack = (avs_read | avs_write) & ~q.ack;
        if (avs_write) begin
            case (avs_address)
                `OFF_CTRL:      n.ctrl = avs_writedata;
                `OFF_XFER_RNG:  begin
                    n.xfer_first = avs_writedata[3:0];
                    n.xfer_last  = avs_writedata[11:8];
                end
                `OFF_INTERLOCK: n.ilk_time = avs_writedata;
                default:        n.ctrl = q.ctrl;
            endcase
        end
        if (avs_read) begin
            case (avs_address)
                `OFF_CTRL:      n.rdata = q.ctrl;
                `OFF_STATUS:    n.rdata = {20'h00000, q.rope_fail, q.vack, q.evac, q.dir,
                                           q.oop, q.firemen, q.special, q.buzz,
                                           q.dopen, q.d1open};
                `OFF_XFER_IN:   n.rdata = {16'h0000, xfer_in};
                `OFF_XFER_OUT:  n.rdata = {16'h0000, q.xout};
                `OFF_XFER_RNG:  n.rdata = {20'h00000, q.xfer_last, 4'h0, q.xfer_first};
                `OFF_INTERLOCK: n.rdata = q.ilk_time;
                `OFF_LANDING:   n.rdata = {29'h00000000, car_pos};
                default:        n.rdata = 32'h00000000;
            endcase
        end
        // lamps, privileged and fail-safe contacts
        n.special = (key_special | key_priority | key_shutdown | key_firemen
                     | key_fire_emerg | car_reserved)
                    & ~higher_prio;
        n.firemen = st_firemen | st_fire_emerg | st_emerg_travel;
        n.oop     = ~(st_fault | st_shutdown);
        // direction: bit 0 up, next bit down
        n.dir = {moving_down, moving_up};
        if (!moving_up && !moving_down && q.ctrl[`CTRL_ONGOING])
            n.dir = {cont_down, cont_up};
        n.buzz = (firemen_start & ~at_fire_land & q.dopen)
                 | (at_landing & overload) | nudging;
        n.voice = '0;
        n.voice[car_pos] = 1'b1;
        // door open indications; contact open means door left closed position
        n.d1open = q.ctrl[`CTRL_LIMSW1] ? limsw1_open : ~door_safety_contact;
        n.dopen  = q.ctrl[`CTRL_LIMSW1] | q.ctrl[`CTRL_LIMSW2]
                   ? (limsw1_open | limsw2_open) : ~door_safety_contact;
        // copy only addresses inside the window
        for (int i = 0; i < `XFER_W; i++)
            n.xout[i] = (4'(i) >= q.xfer_first && 4'(i) <= q.xfer_last)
                        ? xfer_in[i] : 1'b0;
        // evacuation redirect, backup landing tried first
        if (!smoke)          n.evac = 2'd0;
        else if (backup_ok)  n.evac = 2'd1;
        else if (above_ok)   n.evac = 2'd2;
        else                 n.evac = 2'd3;
        // gong: arrival, group options, sound button strokes
        n.door_prev = dev_open1;
        if (q.gong_cnt != 32'h0) begin
            n.gong_cnt = q.gong_cnt - 32'h1;
            if (q.gong_cnt == 32'(`GONG_GAP_CYC)) n.gong = 1'b0;
        end else if (q.strokes != 2'd0) begin
            n.strokes  = q.strokes - 2'd1;
            n.gong     = 1'b1;
            n.gong_cnt = 32'(`GONG_PULSE_CYC + `GONG_GAP_CYC);
        end else begin
            n.gong = 1'b0;
        end
        if (dev_open1 && !q.door_prev && at_dest)
            n.strokes = 2'd1;
        if (q.ctrl[`CTRL_GROUP] && q.ctrl[`CTRL_GONG_DO]) begin
            if (dev_open1 && !q.door_prev) n.strokes = 2'd1;
            if (q.dopen && own_land_call)  n.strokes = 2'd1;
        end
        if (sound_button && pass_landing)
            n.strokes = moving_up ? 2'd2 : 2'd1;
        // door interlock sequences
        case (q.d1)
            elev_pkg::DOOR_IDLE:   if (open_req1) begin
                n.d1 = elev_pkg::DOOR_UNLOCK;
                n.t1 = q.ilk_time;
            end
            elev_pkg::DOOR_UNLOCK: if (q.t1 == 32'h0) n.d1 = elev_pkg::DOOR_OPEN;
                                   else n.t1 = q.t1 - 32'h1;
            elev_pkg::DOOR_OPEN:   if (!open_req1) n.d1 = elev_pkg::DOOR_IDLE;
            default:               n.d1 = elev_pkg::DOOR_IDLE;
        endcase
        case (q.d2)
            elev_pkg::DOOR_IDLE:   if (open_req2 && q.ctrl[`CTRL_TWOSIDE]) begin
                n.d2 = elev_pkg::DOOR_UNLOCK;
                n.t2 = q.ilk_time;
            end
            elev_pkg::DOOR_UNLOCK: if (q.t2 == 32'h0) n.d2 = elev_pkg::DOOR_OPEN;
                                   else n.t2 = q.t2 - 32'h1;
            elev_pkg::DOOR_OPEN:   if (!open_req2) n.d2 = elev_pkg::DOOR_IDLE;
            default:               n.d2 = elev_pkg::DOOR_IDLE;
        endcase
        // visitor sequence: ack held from start to end
        case (q.vis)
            elev_pkg::VIS_IDLE: if (vis_start) begin
                n.vis = elev_pkg::VIS_MAIN;
                n.vack = 1'b1;
            end
            elev_pkg::VIS_MAIN: if (travel_done) n.vis = elev_pkg::VIS_DEST;
            elev_pkg::VIS_DEST: if (travel_done) n.vis = elev_pkg::VIS_DONE;
            elev_pkg::VIS_DONE: begin
                n.vis  = elev_pkg::VIS_IDLE;
                n.vack = 1'b0;
            end
            default:            n.vis = elev_pkg::VIS_IDLE;
        endcase
        // rope brake test strobe and result latch
        n.rope_req = 1'b0;
        if (q.rope_cnt >= ROPE_CYC - 64'd1) begin
            n.rope_cnt  = 64'h0;
            n.rope_req  = 1'b1;
            n.rope_fail = ~rope_brake_ok;
        end else begin
            n.rope_cnt = q.rope_cnt + 64'h1;
        end
        n.att = attendant_in;
    end

    assign dev_open1 = (q.d1 == elev_pkg::DOOR_OPEN);
    assign dev_open2 = (q.d2 == elev_pkg::DOOR_OPEN);
    assign vis_start = visitor_in & q.ctrl[`CTRL_VISITOR] & ~moving_up & ~moving_down
                       & door_safety_contact & ~car_cmds;

    // all state in one register; outputs inactive during reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q          <= '0;
            q.ctrl     <= `CTRL_RESET;
            q.ilk_time <= `INTERLOCK_DEF;
            q.d1       <= elev_pkg::DOOR_IDLE;
            q.d2       <= elev_pkg::DOOR_IDLE;
            q.vis      <= elev_pkg::VIS_IDLE;
            q.xfer_first <= 4'hf;
        end else begin
            q <= n;
        end
    end

    // single-cycle stall: request answered on its second cycle
    assign avs_waitrequest = (avs_read | avs_write) & ~q.ack;
    assign avs_readdata    = q.rdata;
    assign special_lamp = q.special;
    assign firemen_lamp = q.firemen;
    assign out_of_op_ok = q.oop;
    assign dir_lamp     = q.dir;
    assign car_gong     = q.gong;
    assign buzzer       = q.buzz;
    assign voice_pos    = q.voice;
    assign doors_open   = q.dopen;
    assign door1_open   = q.d1open;
    assign interlock1   = q.d1 != elev_pkg::DOOR_IDLE;
    assign interlock2   = q.d2 != elev_pkg::DOOR_IDLE;
    assign door1_cmd    = dev_open1;
    assign door2_cmd    = dev_open2;
    assign xfer_out     = q.xout;
    assign evac_target  = q.evac;
    assign visitor_ack  = q.vack;
    assign visitor_goal = {q.vis == elev_pkg::VIS_DEST, q.vis == elev_pkg::VIS_MAIN};
    assign rope_test_req = q.rope_req;
    assign attendant_q  = q.att;
endmodule

// ===== elev_chk_sva.sv
`timescale 1ns/10ps
module elev_chk #(
    parameter logic [63:0] ROPE_CYC = 64'd100 // rope test interval
) (
    input wire logic       clk,                 // clock
    input wire logic       rst_n,               // reset
    input wire logic       key_special,         // key
    input wire logic       key_priority,        // key
    input wire logic       key_shutdown,        // key
    input wire logic       key_firemen,         // key
    input wire logic       key_fire_emerg,      // key
    input wire logic       car_reserved,        // reservation
    input wire logic       higher_prio,         // overriding status
    input wire logic       st_firemen,          // status
    input wire logic       st_fire_emerg,       // status
    input wire logic       st_emerg_travel,     // status
    input wire logic       st_fault,            // status
    input wire logic       st_shutdown,         // status
    input wire logic       moving_up,           // travel
    input wire logic       nudging,             // nudging
    input wire logic       door_safety_contact, // 1 = closed
    input wire logic       limsw1_open,         // limit switch
    input wire logic       special_lamp,        // out
    input wire logic       firemen_lamp,        // out
    input wire logic       out_of_op_ok,        // out
    input wire logic [1:0] dir_lamp,            // out
    input wire logic       buzzer,              // out
    input wire logic       door1_open,          // out
    input wire logic       interlock1,          // out
    input wire logic       door1_cmd,           // out
    input wire logic       car_gong,            // out
    input wire logic       rope_test_req        // out
);
    // folded input groups
    wire priv = key_special | key_priority | key_shutdown | key_firemen | key_fire_emerg
                | car_reserved;
    wire fire = st_firemen | st_fire_emerg | st_emerg_travel;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // skip the first edge after reset
    chk_special_lamp: assert property ($past(rst_n) |-> special_lamp == $past(priv && !higher_prio))
        else $error("special lamp wrong");
    chk_fire_lamp: assert property ($past(rst_n) |-> firemen_lamp == $past(fire))
        else $error("firemen lamp wrong");
    chk_out_of_op: assert property ($past(rst_n) |-> out_of_op_ok == !$past(st_fault || st_shutdown))
        else $error("out of operation contact wrong");
    chk_dir_up: assert property ($past(rst_n) && $past(moving_up) |-> dir_lamp[0])
        else $error("up lamp missing");
    chk_nudge_buzz: assert property (nudging |=> buzzer)
        else $error("buzzer missing while nudging");
    chk_door1_cause: assert property (door1_open |-> $past(limsw1_open || !door_safety_contact))
        else $error("door 1 open without cause");
    chk_unlock_first: assert property (door1_cmd |-> interlock1 && $past(interlock1))
        else $error("door 1 opened before unlock");
    chk_rope_gap: assert property (rope_test_req |=> !rope_test_req [*8])
        else $error("rope test requested too often");
    cov_special: cover property ($rose(special_lamp));
    cov_door1: cover property ($rose(door1_cmd));
    cov_rope: cover property (rope_test_req);
    cov_gong: cover property ($rose(car_gong));
endmodule

bind elevator_status_output elev_chk #(.ROPE_CYC(ROPE_CYC)) elev_chk_inst (.*);

// ===== door_operator_model.sv
`timescale 1ns/10ps
module door_operator_model (
    input  wire logic clk,                 // clock
    input  wire logic rst_n,               // reset
    input  wire logic door1_cmd,           // open door 1
    input  wire logic door2_cmd,           // open door 2
    output logic      door_safety_contact, // 1 = closed
    output logic      limsw1_open,         // door 1 fully open
    output logic      limsw2_open          // door 2 fully open
);
    int t1;
    int t2;
    // open limits lag the contact
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            t1 <= 0;
            t2 <= 0;
        end else begin
            t1 <= door1_cmd ? t1 + 1 : 0;
            t2 <= door2_cmd ? t2 + 1 : 0;
        end
    end
    assign door_safety_contact = (t1 == 0) && (t2 == 0);
    assign limsw1_open = t1 > 4;
    assign limsw2_open = t2 > 4;
endmodule

// ===== tb_top.sv
`timescale 1ns/10ps
`include "elev_consts.svh"
module tb_top;
    logic clk = 0, rst_n = 0, avs_read = 0, avs_write = 0, avs_waitrequest;
    logic [5:0] avs_address = 0;
    logic [31:0] avs_writedata = 0, avs_readdata, q;
    logic [3:0] avs_byteenable = 4'hf;
    logic key_special = 0, key_priority = 0, key_shutdown = 0, key_firemen = 0, key_fire_emerg = 0;
    logic car_reserved = 0, higher_prio = 0, st_firemen = 0, st_fire_emerg = 0, st_emerg_travel = 0;
    logic st_fault = 0, st_shutdown = 0, moving_up = 0, moving_down = 0, cont_up = 0, cont_down = 0;
    logic at_dest = 0, door_opening = 0, own_land_call = 0, firemen_start = 0, at_fire_land = 0;
    logic at_landing = 0, overload = 0, nudging = 0, pass_landing = 0, sound_button = 0;
    logic open_req1 = 0, open_req2 = 0, smoke = 0, backup_ok = 0, above_ok = 0, visitor_in = 0;
    logic car_cmds = 0, travel_done = 0, rope_brake_ok = 0, door_safety_contact;
    logic limsw1_open, limsw2_open, special_lamp, firemen_lamp, out_of_op_ok, car_gong, buzzer;
    logic doors_open, door1_open, interlock1, interlock2, door1_cmd, door2_cmd, visitor_ack;
    logic rope_test_req;
    logic [2:0] car_pos = 0;
    logic [1:0] dir_lamp, evac_target, visitor_goal;
    logic [4:0] attendant_in = 0, attendant_q;
    logic [15:0] xfer_in = 0, xfer_out;
    logic [7:0] voice_pos;
    int num_errors = 0, checked = 0, n, v;
    elevator_status_output #(.ROPE_CYC(64'd100)) elevator_status_output_inst (.*);
    door_operator_model door_operator_model_inst (.clk, .rst_n, .door1_cmd, .door2_cmd,
        .door_safety_contact, .limsw1_open, .limsw2_open);
    always #5 clk = ~clk;
    task automatic report_and_stop;
        if (num_errors == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one Avalon transfer
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 50);
        if (k >= 50) begin num_errors++; report_and_stop(); end
        q = avs_readdata;
        avs_write <= 0;
        avs_read <= 0;
    endtask
    function automatic logic sig(input int s);
        case (s)
            0: return interlock1;
            1: return door1_cmd;
            3: return interlock2;
            4: return door2_cmd;
            5: return car_gong;
            6: return visitor_ack;
            default: return door1_open;
        endcase
    endfunction
    // bounded wait on an output
    task automatic wait_on(input int s);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (sig(s) !== 1'b1 && n < 200);
        if (n >= 200) begin num_errors++; report_and_stop(); end
    endtask
    task automatic settle;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask
    initial begin
        void'($urandom(8577));
        repeat (9) @(posedge clk);
        @(negedge clk);
        chk("oop_in_reset", 0, out_of_op_ok);
        chk("cmd_in_reset", 0, {door1_cmd, interlock1, special_lamp, buzzer});
        @(posedge clk);
        rst_n <= 1;
        bus(0, `OFF_CTRL, 0); chk("ctrl", 0, q);
        bus(0, `OFF_INTERLOCK, 0); chk("ilk", 32'h000f4240, q);
        bus(0, `OFF_XFER_RNG, 0); chk("rng", 32'h0000000f, q);
        bus(0, 6'h1c, 0); chk("unmapped", 0, q);
        // random status mix
        for (int i = 0; i < 200; i++) begin
            if (i == 100) bus(1, `OFF_XFER_RNG, 32'h00000502);
            @(posedge clk);
            v = $urandom;
            {key_special, key_priority, key_shutdown, key_firemen, key_fire_emerg, car_reserved,
             higher_prio, st_firemen, st_fire_emerg, st_emerg_travel, st_fault, st_shutdown,
             overload, at_landing, nudging, cont_up, pass_landing, sound_button} <= {v[17:2], 2'b00};
            moving_up <= v[20] & !v[19];
            moving_down <= v[21] & !v[20] & !v[19];
            attendant_in <= v[26:22];
            xfer_in <= $urandom;
            settle();
            chk("special", (|{key_special, key_priority, key_shutdown, key_firemen, key_fire_emerg,
                car_reserved}) & !higher_prio, special_lamp);
            chk("fire", st_firemen | st_fire_emerg | st_emerg_travel, firemen_lamp);
            chk("oop", !(st_fault | st_shutdown), out_of_op_ok);
            chk("dir", {moving_down, moving_up}, dir_lamp);
            chk("buzz", (overload & at_landing) | nudging, buzzer);
            chk("xfer", xfer_in & (i >= 100 ? 16'h003c : 16'h0000), xfer_out);
            chk("att", attendant_in, attendant_q);
        end
        @(posedge clk);
        {moving_up, moving_down, overload, nudging, sound_button, pass_landing} <= 0;
        bus(1, `OFF_CTRL, 32'h00000061);
        bus(1, `OFF_INTERLOCK, 32'h00000014);
        for (int p = 0; p < 16; p++) begin
            @(posedge clk);
            {cont_down, cont_up} <= p[0] ? 2'b10 : 2'b01;
            car_pos <= p[3:1];
            at_landing <= 1;
            settle();
            chk("ongoing", p[0] ? 2'b10 : 2'b01, dir_lamp);
            chk("voice", 8'h01 << p[3:1], voice_pos);
        end
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            {smoke, backup_ok, above_ok} <= {k != 0, k == 1, k == 2};
            settle();
            chk("evac", k, evac_target);
        end
        for (int d = 0; d < 2; d++) begin
            @(posedge clk);
            {open_req2, open_req1} <= d ? 2'b10 : 2'b01;
            wait_on(3 * d);
            wait_on(3 * d + 1);
            chk("unlock_delay", 1, n >= 20 && n <= 22);
            if (d == 0) begin
                wait_on(2);
                chk("doors_open", 1, doors_open);
            end
            @(posedge clk);
            {open_req2, open_req1} <= 0;
            repeat (40) @(posedge clk);
        end
        @(posedge clk);
        visitor_in <= 1;
        wait_on(6);
        chk("goal", 1, visitor_goal);
        n = 0;
        repeat (250) @(posedge clk) n += (rope_test_req === 1'b1);
        chk("rope_pulses", 1, n >= 2 && n <= 3);
        @(posedge clk);
        {at_dest, door_opening, open_req1} <= 3'b111;
        wait_on(5);
        chk("gong", 1, car_gong);
        report_and_stop();
    end
endmodule
